// ---- ssr_cause_if.sv ----
// ssr_cause_if: debounced manual cause from debouncer to sequencer.
// assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface ssr_cause_if;
  logic manual_active;
  modport src (output manual_active);
  modport snk (input  manual_active);
endinterface : ssr_cause_if
`default_nettype wire

// ---- ssr_cpu_model.sv ----
// ssr_cpu_model: processor reset input fed by the supervisor.
// assumes both reset outputs are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ssr_cpu_model (
  input  wire logic clk_sys,
  input  wire logic reset_out_n,
  input  wire logic reset_out,
  output var  int   n_resets,
  output var  logic pair_bad
);
  logic last_n;

  // ==========================================================
  // start idle, no resets seen yet
  initial begin
    n_resets = 0;
    pair_bad = 1'b0;
    last_n   = 1'b0;
  end

  // ==========================================================
  // count entries into reset, flag a broken output pair
  always @(negedge clk_sys) begin
    if (last_n === 1'b1 && reset_out_n === 1'b0) begin
      n_resets <= n_resets + 1;
    end
    if (reset_out !== ~reset_out_n) begin
      pair_bad <= 1'b1;
    end
    last_n <= reset_out_n;
  end
endmodule : ssr_cpu_model
`default_nettype wire

// ---- ssr_debounce.sv ----
// ssr_debounce: synchronise and debounce the manual reset pin.
// assumes the pin has a pull-up outside, so open reads high.
`timescale 1ns/1ps
`default_nettype none
module ssr_debounce #(
  parameter int DB_CYCLES = ssr_pkg::MANUAL_DB_CYCLES
) (
  input  wire logic   clk_sys,
  input  wire logic   reset,
  input  wire logic   manual_reset_n,
  ssr_cause_if.src    cause
);
  // assertions below all run on clk_sys, off during reset
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (reset);

  localparam int DB_W = $clog2(DB_CYCLES + 1);

  typedef struct packed {
    logic            sync1;
    logic            sync2;
    logic            stable;
    logic [DB_W-1:0] cnt;
  } ssr_db_type;

  ssr_db_type st;
  ssr_db_type next_st;

  // ==========================================================
  // two flops, then a stability counter
  always_comb begin
    next_st       = st;
    next_st.sync1 = manual_reset_n;
    next_st.sync2 = st.sync1;
    if (st.sync2 == st.stable) begin
      next_st.cnt = '0; // bounce back clears the count
    end else if (int'(st.cnt) == DB_CYCLES - 1) begin
      next_st.stable = st.sync2; // level held long enough
      next_st.cnt    = '0;
    end else begin
      next_st.cnt = st.cnt + DB_W'(1);
    end
  end

  // state register, pin reads released after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st.sync1  <= ssr_pkg::SYNC_RESET_VAL;
      st.sync2  <= ssr_pkg::SYNC_RESET_VAL;
      st.stable <= ssr_pkg::SYNC_RESET_VAL;
      st.cnt    <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cause.manual_active = ~st.stable;

  // ==========================================================
  // checks
  db_accept_a: assert property (
    st.stable != $past(st.stable) |->
      int'($past(st.cnt)) == DB_CYCLES - 1 && $past(st.sync2) == st.stable)
    else $error("debounced level changed without a full stable count");
  glitch_ignore_a: assert property (
    $fell(st.sync2) ##1 st.sync2 [*2] |-> st.stable == $past(st.stable, 2))
    else $error("short low pulse reached the debounced level");
endmodule : ssr_debounce
`default_nettype wire

// ---- ssr_pkg.sv ----
// ssr_pkg: constants for the supply reset supervisor.
// assumes a single 100 MHz system clock.
`default_nettype none
package ssr_pkg;
  // ==========================================================
  // clock
  localparam int CLK_MHZ            = 100;
  localparam int CLK_KHZ            = 100000;
  // ==========================================================
  // reset hold period, nominal and limits (ms)
  localparam int HOLD_PERIOD_MS     = 180;
  localparam int HOLD_MIN_MS        = 140;
  localparam int HOLD_MAX_MS        = 560;
  localparam int HOLD_CYCLES        = HOLD_PERIOD_MS * CLK_KHZ;
  localparam int HOLD_MIN_CYCLES    = HOLD_MIN_MS * CLK_KHZ;
  localparam int HOLD_MAX_CYCLES    = HOLD_MAX_MS * CLK_KHZ;
  // ==========================================================
  // supply glitch filter, shortest dip caught (us), rounds down
  localparam int SUPPLY_DIP_HI_US   = 40;
  localparam int SUPPLY_DIP_LO_US   = 20;
  localparam int SUPPLY_HI_CYCLES   = SUPPLY_DIP_HI_US * CLK_MHZ;
  localparam int SUPPLY_LO_CYCLES   = SUPPLY_DIP_LO_US * CLK_MHZ;
  // ==========================================================
  // manual input: glitch immunity, debounce, least pulse (ns)
  localparam int MANUAL_GLITCH_NS   = 100;
  localparam int MANUAL_DEBOUNCE_NS = 1000;
  localparam int MANUAL_MIN_NS      = 10000;
  localparam int MANUAL_DB_CYCLES   = (MANUAL_DEBOUNCE_NS * CLK_MHZ) / 1000;
  localparam int MANUAL_GL_CYCLES   = (MANUAL_GLITCH_NS * CLK_MHZ) / 1000;
  // ==========================================================
  // reset values
  localparam logic SYNC_RESET_VAL   = 1'b1;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    SSR_ASSERT   = 3'h1,
    SSR_HOLD     = 3'h2,
    SSR_RELEASED = 3'h4
  } ssr_state_type;
endpackage : ssr_pkg
`default_nettype wire

// ---- ssr_supervisor.sv ----
// ssr_supervisor: supervisory reset sequencer, top level.
// assumes supply_low is a synchronous level on clk_sys and the
// manual pin comes from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module ssr_supervisor #(
  parameter int HOLD_CYCLES  = ssr_pkg::HOLD_CYCLES,
  parameter bit HIGH_VARIANT = 1'b0,
  parameter int DB_CYCLES    = ssr_pkg::MANUAL_DB_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic supply_low,
  input  wire logic manual_reset_n,
  output var  logic reset_out_n,
  output var  logic reset_out
);
  // assertions below all run on clk_sys, off during reset
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (reset);

  // shortest dip caught for the chosen threshold variant
  localparam int FILT_CYCLES = HIGH_VARIANT ? ssr_pkg::SUPPLY_HI_CYCLES
                                            : ssr_pkg::SUPPLY_LO_CYCLES;
  localparam int FILT_W      = $clog2(FILT_CYCLES + 1);
  localparam int HOLD_W      = $clog2(HOLD_CYCLES + 1);

  typedef struct packed {
    ssr_pkg::ssr_state_type state;
    logic [FILT_W-1:0]      filt_cnt;
    logic                   supply_cause;
    logic [HOLD_W-1:0]      hold_cnt;
    logic                   out_n;
    logic                   out;
  } ssr_top_type;

  ssr_top_type st;
  ssr_top_type next_st;
  logic        any_cause;

  // ==========================================================
  // release decode, shared by both outputs
  function automatic logic is_released(ssr_pkg::ssr_state_type s);
    return s == ssr_pkg::SSR_RELEASED;
  endfunction : is_released

  // ==========================================================
  // manual input path
  ssr_cause_if cause_link ();

  ssr_debounce #(
    .DB_CYCLES (DB_CYCLES)
  ) u_debounce (
    .clk_sys        (clk_sys),
    .reset          (reset),
    .manual_reset_n (manual_reset_n),
    .cause          (cause_link.src)
  );

  assign any_cause = st.supply_cause | cause_link.manual_active;

  // ==========================================================
  // next state: supply filter, then hold sequencer
  always_comb begin
    next_st = st;
    // supply filter: a dip must last the whole window
    if (!supply_low) begin
      next_st.supply_cause = 1'b0;
      next_st.filt_cnt     = '0;
    end else if (!st.supply_cause) begin
      if (int'(st.filt_cnt) == FILT_CYCLES - 1) begin
        next_st.supply_cause = 1'b1;
        next_st.filt_cnt     = '0;
      end else begin
        next_st.filt_cnt = st.filt_cnt + FILT_W'(1);
      end
    end
    // sequencer
    case (st.state)
      ssr_pkg::SSR_ASSERT: begin
        next_st.hold_cnt = '0;
        if (!any_cause) begin
          next_st.state = ssr_pkg::SSR_HOLD;
        end
      end
      ssr_pkg::SSR_HOLD: begin
        if (any_cause) begin
          next_st.hold_cnt = '0;
          next_st.state    = ssr_pkg::SSR_ASSERT;
        end else if (int'(st.hold_cnt) == HOLD_CYCLES - 1) begin
          next_st.state = ssr_pkg::SSR_RELEASED;
        end else begin
          next_st.hold_cnt = st.hold_cnt + HOLD_W'(1);
        end
      end
      ssr_pkg::SSR_RELEASED: begin
        if (any_cause) begin
          next_st.hold_cnt = '0;
          next_st.state    = ssr_pkg::SSR_ASSERT;
        end
      end
      default: begin
        next_st.hold_cnt = '0;
        next_st.state    = ssr_pkg::SSR_ASSERT;
      end
    endcase
    // both outputs from one decision
    next_st.out_n = is_released(next_st.state);
    next_st.out   = !is_released(next_st.state);
  end

  // state register, reset held asserted
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st.state        <= ssr_pkg::SSR_ASSERT;
      st.filt_cnt     <= '0;
      st.supply_cause <= 1'b0;
      st.hold_cnt     <= '0;
      st.out_n        <= 1'b0;
      st.out          <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign reset_out_n = st.out_n;
  assign reset_out   = st.out;

  // ==========================================================
  // checks
  sequence causes_gone_s;
    st.state == ssr_pkg::SSR_HOLD && !any_cause;
  endsequence

  sequence hold_done_s;
    causes_gone_s ##0 int'(st.hold_cnt) == HOLD_CYCLES - 1;
  endsequence

  out_complement_a: assert property (
    reset_out == !reset_out_n)
    else $error("active-high output is not the complement");
  supply_asserts_a: assert property (
    st.supply_cause |=> !reset_out_n)
    else $error("reset released while supply below threshold");
  manual_asserts_a: assert property (
    cause_link.manual_active |=> !reset_out_n)
    else $error("reset released while manual input low");
  timer_clear_a: assert property (
    st.supply_cause |=> st.hold_cnt == '0)
    else $error("hold timer not cleared on supply dip");
  hold_start_a: assert property (
    causes_gone_s ##1 causes_gone_s |->
      st.hold_cnt == $past(st.hold_cnt) + 1'b1)
    else $error("hold count did not advance after recovery");
  hold_release_a: assert property (
    hold_done_s |=> reset_out_n)
    else $error("reset not released at end of hold");
  no_early_release_a: assert property (
    $rose(reset_out_n) |-> $past(st.state) == ssr_pkg::SSR_HOLD &&
      int'($past(st.hold_cnt)) == HOLD_CYCLES - 1)
    else $error("reset released before the full hold count");
  filter_window_a: assert property (
    $rose(st.supply_cause) |-> $past(supply_low) &&
      int'($past(st.filt_cnt)) == FILT_CYCLES - 1)
    else $error("supply cause taken before the filter window");
  filter_short_a: assert property (
    !supply_low ##1 supply_low [*3] ##1 !supply_low |-> !st.supply_cause)
    else $error("short supply dip was not filtered");

  // ==========================================================
  // sequencer steps, one edge at a time
  sequence cause_in_hold_s;
    st.state == ssr_pkg::SSR_HOLD && any_cause;
  endsequence

  sequence manual_gone_s;
    $fell(cause_link.manual_active) && !st.supply_cause;
  endsequence

  state_onehot_a: assert property (
    $onehot(st.state))
    else $error("sequencer state is not one-hot");
  cause_to_assert_a: assert property (
    any_cause |=> st.state == ssr_pkg::SSR_ASSERT)
    else $error("a reset cause did not force the assert state");
  hold_abort_a: assert property (
    cause_in_hold_s |=> st.state == ssr_pkg::SSR_ASSERT && st.hold_cnt == '0)
    else $error("cause during hold did not clear the timer");
  assert_to_hold_a: assert property (
    st.state == ssr_pkg::SSR_ASSERT && !any_cause |=>
      st.state == ssr_pkg::SSR_HOLD && st.hold_cnt == '0)
    else $error("hold did not start from zero after recovery");
  manual_release_a: assert property (
    manual_gone_s |=> st.state == ssr_pkg::SSR_HOLD && !reset_out_n)
    else $error("manual release did not start a held reset");
  release_stays_a: assert property (
    st.state == ssr_pkg::SSR_RELEASED && !any_cause |=> reset_out_n)
    else $error("reset asserted again with no cause");
  hold_bound_a: assert property (
    int'(st.hold_cnt) <= HOLD_CYCLES - 1)
    else $error("hold count ran past its terminal value");
  filter_idle_a: assert property (
    !supply_low |=> st.filt_cnt == '0 && !st.supply_cause)
    else $error("supply filter not cleared on recovery");
  filter_count_a: assert property (
    supply_low && !st.supply_cause && int'(st.filt_cnt) < FILT_CYCLES - 1
      |=> st.filt_cnt == $past(st.filt_cnt) + 1'b1 && !st.supply_cause)
    else $error("supply filter did not count the dip");
endmodule : ssr_supervisor
`default_nettype wire

// ---- test_supply_reset_supervisor.sv ----
// test_supply_reset_supervisor: self-checking bench for ssr_supervisor.
// assumes short hold and debounce parameters; manual pin idles high.
`timescale 1ns/1ps
`default_nettype none
module test_supply_reset_supervisor;
  localparam int HOLD = 50;
  localparam int DB   = 4;
  typedef struct {int dip; int low; logic hit; int lo; int hi;} ssr_row_type;
  logic clk_sys        = 1'b0;
  logic reset          = 1'b1;
  logic supply_low     = 1'b0;
  logic manual_reset_n = 1'b1; // open pin reads high
  logic reset_out_n;
  logic reset_out;
  logic pair_bad;
  logic seen;
  int   n_resets;
  int   n_mismatch = 0;
  int   n_tests    = 0;
  int   cyc        = 0;
  int   got;
  int   base;
  ssr_row_type rows [8] = '{
    '{2100, 0, 1'b1, HOLD, HOLD + 4},
    '{ssr_pkg::SUPPLY_LO_CYCLES, 0, 1'b1, HOLD, HOLD + 4},
    '{ssr_pkg::SUPPLY_LO_CYCLES - 1, 0, 1'b0, 0, 0},
    '{1000, 0, 1'b0, 0, 0},
    '{3, 0, 1'b0, 0, 0},
    '{0, 1000, 1'b1, HOLD + DB, HOLD + DB + 6},
    '{0, 1, 1'b0, 0, 0},
    '{0, 3, 1'b0, 0, 0}};

  ssr_supervisor #(.HOLD_CYCLES(HOLD), .HIGH_VARIANT(1'b0), .DB_CYCLES(DB))
    ssr_supervisor_inst (.clk_sys(clk_sys), .reset(reset),
    .supply_low(supply_low), .manual_reset_n(manual_reset_n),
    .reset_out_n(reset_out_n), .reset_out(reset_out));

  ssr_cpu_model ssr_cpu_model_inst (.clk_sys(clk_sys),
    .reset_out_n(reset_out_n), .reset_out(reset_out),
    .n_resets(n_resets), .pair_bad(pair_bad));

  // ==========================================================
  // clock and hang guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end

  // ==========================================================
  // compare helpers
  task automatic check(string name, logic [31:0] exp, logic [31:0] val);
    n_tests = n_tests + 1;
    if (val !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %0d seen %0d", name, exp, val);
    end
  endtask : check

  task automatic range(string name, int lo, int hi, int val);
    n_tests = n_tests + 1;
    if (val < lo || val > hi) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %0d..%0d seen %0d", name, lo, hi, val);
    end
  endtask : range

  // drive inputs for n cycles at the falling edge, note any reset
  task automatic drive(int n, logic s, logic m);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      supply_low     = s;
      manual_reset_n = m;
      if (reset_out_n === 1'b0) seen = 1'b1;
    end
  endtask : drive

  // cycles until reset output releases, bounded
  task automatic measure();
    got = 0;
    while (reset_out_n !== 1'b1 && got < 300) begin
      @(negedge clk_sys);
      got = got + 1;
    end
  endtask : measure

  task automatic do_reset(string name);
    @(negedge clk_sys);
    reset = 1'b1;
    drive(2, 1'b0, 1'b1);
    check("reset_out_n_in_reset", 0, reset_out_n);
    reset = 1'b0;
    measure();
    range(name, HOLD, HOLD + 4, got);
    $display("test %s done", name);
  endtask : do_reset

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================
  // main sequence: table rows, then hand-written cases
  initial begin
    do_reset("power_on");
    foreach (rows[i]) begin
      drive(10, 1'b0, 1'b1);
      seen = 1'b0;
      drive(rows[i].dip + rows[i].low, rows[i].dip > 0, rows[i].low == 0);
      drive(rows[i].hit ? 2 : DB + 8, 1'b0, 1'b1);
      check("row_asserted", rows[i].hit, seen);
      measure();
      range("row_hold", rows[i].lo, rows[i].hi, got);
      $display("test row %0d done", i);
    end
    // second dip in mid-hold restarts the full hold
    seen = 1'b0;
    drive(2100, 1'b1, 1'b1);
    check("redip_asserted", 1, seen);
    drive(20, 1'b0, 1'b1);
    check("mid_hold_low", 0, reset_out_n);
    drive(2100, 1'b1, 1'b1);
    drive(1, 1'b0, 1'b1);
    measure();
    range("restart_hold", HOLD, HOLD + 4, got);
    $display("test redip done");
    // bouncing switch gives a single reset sequence
    base = n_resets;
    seen = 1'b0;
    for (int i = 0; i < 10; i++) begin
      drive(1, 1'b0, 1'b0);
      drive(1, 1'b0, 1'b1);
    end
    check("bounce_quiet", 0, seen);
    drive(200, 1'b0, 1'b0);
    // release bounces before the switch settles high
    for (int i = 0; i < 5; i++) begin
      drive(1, 1'b0, 1'b1);
      drive(1, 1'b0, 1'b0);
    end
    drive(1, 1'b0, 1'b1);
    measure();
    range("bounce_hold", HOLD + DB, HOLD + DB + 6, got);
    check("bounce_resets", 1, n_resets - base);
    $display("test bounce done");
    do_reset("mid_run_reset");
    check("pair_bad", 0, pair_bad);
    give_verdict();
  end
endmodule : test_supply_reset_supervisor
`default_nettype wire
